// [rtl/csk_top.sv]
// Execution logic for the three compare-and-skip instructions.
// Assumes the fetch unit presents the next fetched word during Q4 and that
// data memory returns the read byte within the Q2 phase.
//
// What this block does
// - Greater compare 0110 010a skips if greater.
// - Less compare uses opcode 0110 000a.
// - Less compare skips only if f < W.
// - Unsigned f minus W; no flags, no writeback.
// - True condition discards fetch, runs one no-operation.
// - Skipped two-word instruction costs two no-operations.
// - Access bit zero selects the access bank.
// - Access bit one uses bank select register.
// - Extended set, low address: indexed literal offset.
`timescale 1ns/1ps
`default_nettype none
`include "csk_regs.svh"

module csk_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] instr_word,
  input  wire logic        fetched_two_word,
  input  wire logic [7:0]  working_register,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        extended_set_enable,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic      [1:0]  phase,
  output logic      [11:0] mem_addr,
  output logic             mem_read,
  output logic             discard_fetched,
  output logic             skip_taken
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  // The core leaves reset only after two clean edges, so a release close to
  // an edge cannot leave part of the state still held in reset.
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  function automatic csk_pkg::csk_dec_type decode_word(input logic [15:0] w);
    csk_pkg::csk_dec_type d;
    d.is_cmp = 1'b0;
    d.kind   = csk_pkg::CSK_NONE;
    d.access = w[8];
    d.f      = w[7:0];
    if (w[15:12] == `CSK_OP_HI) begin
      if (w[11:9] == `CSK_KIND_LT) begin
        d.is_cmp = 1'b1;
        d.kind   = csk_pkg::CSK_LT;
      end else if (w[11:9] == `CSK_KIND_EQ) begin
        d.is_cmp = 1'b1;
        d.kind   = csk_pkg::CSK_EQ;
      end else if (w[11:9] == `CSK_KIND_GT) begin
        d.is_cmp = 1'b1;
        d.kind   = csk_pkg::CSK_GT;
      end
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand address.

  // A clear access bit picks the fixed bank, whose bytes up to 5Fh are data page zero
  // and whose bytes above 5Fh are the special page. With the extended set on, the low
  // part is instead an offset from the index base.
  function automatic logic [11:0] operand_addr(
    input logic [15:0] w,
    input logic        ext_on,
    input logic [11:0] base,
    input logic [3:0]  bank
  );
    logic [11:0] a;
    a = {bank, w[7:0]};
    if (!w[8] && ext_on && w[7:0] <= `CSK_ACCESS_LIMIT) begin
      a = 12'(base + {4'h0, w[7:0]});
    end else if (!w[8] && w[7:0] <= `CSK_ACCESS_LIMIT) begin
      a = {`CSK_LOW_PAGE, w[7:0]};
    end else if (!w[8]) begin
      a = {`CSK_SFR_PAGE, w[7:0]};
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Skip condition.

  // The difference is f minus W over nine bits, so bit 8 is the borrow.
  function automatic logic skip_holds(
    input csk_pkg::csk_kind_type kind,
    input logic [8:0]            d
  );
    logic hit;
    hit = 1'b0;
    case (kind)
      csk_pkg::CSK_GT: hit = !d[8] && d[7:0] != 8'h00;
      csk_pkg::CSK_LT: hit = d[8];
      csk_pkg::CSK_EQ: hit = d[7:0] == 8'h00;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Execution state.

  csk_pkg::csk_phase_type ph;
  csk_pkg::csk_phase_type next_ph;
  logic [15:0]            ir;
  logic [15:0]            next_ir;
  csk_pkg::csk_dec_type   dec;
  csk_pkg::csk_dec_type   next_dec;
  logic [11:0]            next_mem_addr;
  logic                   next_mem_read;
  logic [7:0]             fdata;
  logic [7:0]             next_fdata;
  logic                   cond;
  logic                   next_cond;
  logic [1:0]             skip_left;
  logic [1:0]             next_skip_left;
  logic                   next_discard;
  logic                   next_skip_taken;
  logic [8:0]             diff;

  always_comb begin
    next_ph         = ph;
    next_ir         = ir;
    next_dec        = dec;
    next_mem_addr   = mem_addr;
    next_mem_read   = 1'b0;
    next_fdata      = fdata;
    next_cond       = cond;
    next_skip_left  = skip_left;
    next_discard    = discard_fetched;
    next_skip_taken = 1'b0;
    diff            = {1'b0, fdata} - {1'b0, working_register};
    case (ph)
      csk_pkg::CSK_Q1: begin
        next_ph  = csk_pkg::CSK_Q2;
        next_dec      = decode_word(ir);
        next_mem_addr = operand_addr(ir, extended_set_enable, index_base, bank_select_register);
        next_mem_read = next_dec.is_cmp;
      end
      csk_pkg::CSK_Q2: begin
        next_ph = csk_pkg::CSK_Q3;
        if (mem_read) begin
          next_fdata = mem_rdata;
        end
      end
      csk_pkg::CSK_Q3: begin
        next_ph   = csk_pkg::CSK_Q4;
        next_cond = 1'b0;
        if (dec.is_cmp) begin
          next_cond = skip_holds(dec.kind, diff);
        end
      end
      default: begin
        // Q4 writes nothing back; the skip bookkeeping and the load of the fetched word move here.
        next_ph = csk_pkg::CSK_Q1;
        // A skipped two-word instruction has both words replaced, so the
        // count of no-operation cycles starts at two.
        if (cond) begin
          next_skip_taken = 1'b1;
          next_skip_left  = fetched_two_word ? `CSK_SKIP_TWO : `CSK_SKIP_ONE;
        end else if (skip_left != `CSK_SKIP_NONE) begin
          next_skip_left = skip_left - `CSK_SKIP_ONE;
        end
        next_discard = next_skip_left != `CSK_SKIP_NONE;
        next_ir      = next_discard ? `CSK_NOP_WORD : instr_word;
        next_cond    = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ph              <= csk_pkg::CSK_Q1;
      ir              <= `CSK_NOP_WORD;
      dec             <= '0;
      mem_addr        <= 12'h000;
      mem_read        <= 1'b0;
      fdata           <= 8'h00;
      cond            <= 1'b0;
      skip_left       <= `CSK_SKIP_NONE;
      discard_fetched <= 1'b0;
      skip_taken      <= 1'b0;
      phase           <= 2'h0;
    end else begin
      ph              <= next_ph;
      ir              <= next_ir;
      dec             <= next_dec;
      mem_addr        <= next_mem_addr;
      mem_read        <= next_mem_read;
      fdata           <= next_fdata;
      cond            <= next_cond;
      skip_left       <= next_skip_left;
      discard_fetched <= next_discard;
      skip_taken      <= next_skip_taken;
      phase           <= next_ph;
    end
  end

endmodule

`default_nettype wire

// [rtl/csk_regs.svh]
// Constants for the compare-and-skip execution block.
// Assumes a core with a 16-bit instruction word and a 12-bit data address.
`ifndef CSK_REGS_SVH
`define CSK_REGS_SVH

// Opcode fields: upper nibble and the three-bit kind field in bits 11:9.
`define CSK_OP_HI        4'h6
`define CSK_KIND_LT      3'h0
`define CSK_KIND_EQ      3'h1
`define CSK_KIND_GT      3'h2

// Addressing constants.
`define CSK_ACCESS_LIMIT 8'h5f
`define CSK_SFR_PAGE     4'hf
`define CSK_LOW_PAGE     4'h0

// Instruction word that stands in for a discarded fetch.
`define CSK_NOP_WORD     16'h0000

// Reset values and skip lengths in instruction cycles.
`define CSK_SKIP_NONE    2'h0
`define CSK_SKIP_ONE     2'h1
`define CSK_SKIP_TWO     2'h2

`endif

// [rtl/csk_pkg.sv]
// Types for the compare-and-skip execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package csk_pkg;

  typedef enum logic [1:0] {
    CSK_Q1 = 2'h0,
    CSK_Q2 = 2'h1,
    CSK_Q3 = 2'h2,
    CSK_Q4 = 2'h3
  } csk_phase_type;

  typedef enum logic [1:0] {
    CSK_LT   = 2'h0,
    CSK_EQ   = 2'h1,
    CSK_GT   = 2'h2,
    CSK_NONE = 2'h3
  } csk_kind_type;

  typedef struct packed {
    logic         is_cmp;
    csk_kind_type kind;
    logic         access;
    logic [7:0]   f;
  } csk_dec_type;

endpackage

// [bench/csk_asserts.sv]
// Port checks for the compare-and-skip block.
// Assumes one clock and the top module's active-low reset.
`timescale 1ns/1ps
`default_nettype none
module csk_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] instr_word,
  input wire logic        fetched_two_word,
  input wire logic [7:0]  working_register,
  input wire logic [3:0]  bank_select_register,
  input wire logic [7:0]  mem_rdata,
  input wire logic [1:0]  phase,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_read,
  input wire logic        discard_fetched,
  input wire logic        skip_taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_in_q2: assert property (mem_read |-> phase == 2'h1 ##1 !mem_read)
    else $error("read outside Q2");
  a_cmp_reads: assert property (phase == 2'h3 && instr_word[15:9] < 7'h33
    && instr_word[15:12] == 4'h6 |-> ##2 (mem_read || discard_fetched)) else $error("no read");
  a_gt_skip: assert property ($past(mem_read, 3) && ($past(instr_word, 5) & 16'h0e00) == 16'h0400
    |-> skip_taken == ($past(mem_rdata, 3) > $past(working_register, 2))) else $error("gt");
  a_lt_skip: assert property ($past(mem_read, 3) && ($past(instr_word, 5) & 16'h0e00) == 16'h0000
    |-> skip_taken == ($past(mem_rdata, 3) < $past(working_register, 2))) else $error("lt");
  a_eq_skip: assert property ($past(mem_read, 3) && ($past(instr_word, 5) & 16'h0e00) == 16'h0200
    |-> skip_taken == ($past(mem_rdata, 3) == $past(working_register, 2))) else $error("eq");
  a_skip_discard: assert property (skip_taken |-> phase == 2'h0 && $rose(discard_fetched)
    ##1 !skip_taken) else $error("skip pulse");
  a_discard_len: assert property ($rose(discard_fetched) |-> skip_taken && discard_fetched[*4]
    ##1 discard_fetched == $past(fetched_two_word, 5)) else $error("discard length");
  a_bank_addr: assert property (mem_read && $past(instr_word[8], 2) |-> mem_addr ==
    {$past(bank_select_register), $past(instr_word[7:0], 2)}) else $error("bank address");
endmodule
bind csk_top csk_asserts csk_asserts_i (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
  .fetched_two_word(fetched_two_word), .working_register(working_register),
  .bank_select_register(bank_select_register), .mem_rdata(mem_rdata), .phase(phase),
  .mem_addr(mem_addr), .mem_read(mem_read), .discard_fetched(discard_fetched),
  .skip_taken(skip_taken));
`default_nettype wire

// [bench/csk_mem_model.sv]
// Data memory behind the compare-and-skip block.
// Assumes the bench fills mem before each instruction.
`timescale 1ns/1ps
`default_nettype none
module csk_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_read,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last;
  // Outside a read the bus shows the inverse of the last byte, never a stale copy.
  assign mem_rdata = mem_read ? mem[mem_addr] : ~last;
  always_ff @(posedge clk) if (mem_read) last <= mem[mem_addr];
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Random compare-and-skip traffic against a bench model.
// Assumes the design, the memory model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, two = 1'b0, ext = 1'b0, rd, disc, skip;
  logic [15:0] iw = 16'h0000;
  logic [7:0] w = 8'h00, rdata;
  logic [3:0] bank = 4'h0;
  logic [11:0] base = 12'h000, addr;
  logic [1:0] phase;
  int fails = 0, comparisons = 0;
  csk_top csk_top_i (.clk(clk), .rst_b(rst_b), .instr_word(iw), .fetched_two_word(two),
    .working_register(w), .bank_select_register(bank), .extended_set_enable(ext),
    .index_base(base), .mem_rdata(rdata), .phase(phase), .mem_addr(addr), .mem_read(rd),
    .discard_fetched(disc), .skip_taken(skip));
  csk_mem_model csk_mem_model_i (.clk(clk), .mem_addr(addr), .mem_read(rd), .mem_rdata(rdata));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One instruction, presented at Q4 and followed through its skip cycles.
  task automatic run_one(input int kind, input bit tie);
    int n, exp_skip;
    logic [7:0] val;
    logic [11:0] ea;
    n = 0;
    while (phase !== 2'h3) begin
      @(negedge clk);
      if (++n > 20) begin fails++; tally_and_finish(); end
    end
    iw = {4'h6, 3'(kind), 9'($urandom)};
    {two, ext, bank, base, w} = 26'($urandom);
    val = tie ? w : 8'($urandom);
    ea = iw[8] ? {bank, iw[7:0]} : iw[7:0] > 8'h5f ? {4'hf, iw[7:0]} :
      ext ? base + 12'(iw[7:0]) : {4'h0, iw[7:0]};
    csk_mem_model_i.mem[ea] = val;
    exp_skip = (kind == 0 && val < w) || (kind == 1 && val == w) || (kind == 2 && val > w);
    @(negedge clk);
    // Words fetched behind the compare are no-operations, so no stale compare reruns.
    iw = 16'h0000;
    @(negedge clk);
    check(12'(phase), 12'h001);
    check(12'(rd), 12'(kind < 3));
    if (kind < 3) check(addr, ea);
    repeat (3) @(negedge clk);
    check(12'(skip), 12'(exp_skip));
    n = 0;
    while (disc === 1'b1 && n < 9) begin n++; @(negedge clk); end
    check(12'(n), exp_skip ? (two ? 12'h008 : 12'h004) : 12'h000);
  endtask
  initial begin
    void'($urandom(37510));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (200) run_one($urandom_range(4, 0), 1'($urandom));
    tally_and_finish();
  end
endmodule
`default_nettype wire
